// *** rtl/tew_bus_if.sv ***
// Open-drain two-wire bus joining the controller and the EEPROM.
`timescale 1ns/1ps
interface tew_bus_if;
    logic scl_o;
    logic scl_oe;
    logic h_sda_o;
    logic h_sda_oe;
    logic d_sda_o;
    logic d_sda_oe;
    logic scl;
    logic sda;

    // Pulled high unless some party drives its output low.
    assign scl = ~(scl_oe & ~scl_o);
    assign sda = ~(h_sda_oe & ~h_sda_o) & ~(d_sda_oe & ~d_sda_o);

    modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
    modport host (input sda, output scl_o, output scl_oe,
                  output h_sda_o, output h_sda_oe);
endinterface : tew_bus_if

// *** rtl/tew_consts.svh ***
// Constants shared by both ends of the two-wire EEPROM link.
`ifndef TEW_CONSTS_SVH
`define TEW_CONSTS_SVH
// ---------------------------------------------------------------
// Clock and timing
// ---------------------------------------------------------------
`define TEW_CLK_MHZ          125
`define TEW_PROG_TIME_MS     5
`define TEW_PROG_CYCLES      (`TEW_PROG_TIME_MS * 1000 * `TEW_CLK_MHZ)
`define TEW_SCL_QTR_NS       250
`define TEW_SCL_QTR_CYC      ((`TEW_SCL_QTR_NS * `TEW_CLK_MHZ + 999) / 1000)
// ---------------------------------------------------------------
// Addressing and array layout
// ---------------------------------------------------------------
`define TEW_DEV_CODE         4'ha
`define TEW_ADDR_W           17
`define TEW_MEM_BYTES        131072
`define TEW_PAGE_BYTES       256
`define TEW_BITS_PER_WORD    4'h8
`endif

// *** rtl/tew_eeprom_dev.sv ***
// Two-wire serial EEPROM target with page buffer and timed programming.
`timescale 1ns/1ps
`include "tew_consts.svh"
module tew_eeprom_dev
    import tew_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = `TEW_PROG_CYCLES
) (
    input  wire logic clock,
    input  wire logic reset_n,
    tew_bus_if.dev    bus,
    input  wire logic chip_select_hi_pin,
    input  wire logic chip_select_lo_pin,
    input  wire logic write_protect,
    output logic      busy
);
    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    logic [7:0]                mem   [0:`TEW_MEM_BYTES-1];
    logic [7:0]                pbuf  [0:`TEW_PAGE_BYTES-1];
    logic [`TEW_PAGE_BYTES-1:0] dirty_r;

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [2:0]                scl_s;
    logic [2:0]                sda_s;
    logic [1:0]                csh_s;
    logic [1:0]                csl_s;
    logic [1:0]                wp_s;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            csh_s <= 2'h0;
            csl_s <= 2'h0;
            wp_s  <= 2'h0;
        end else begin
            scl_s <= {scl_s[1:0], bus.scl};
            sda_s <= {sda_s[1:0], bus.sda};
            csh_s <= {csh_s[0], chip_select_hi_pin};
            csl_s <= {csl_s[0], chip_select_lo_pin};
            wp_s  <= {wp_s[0], write_protect};
        end
    end

    // Only stages 1 and 2 are read, so stage 0 stays a pure metastability
    // guard.
    wire scl_rise  = scl_s[1] & ~scl_s[2];
    wire scl_fall  = ~scl_s[1] & scl_s[2];
    wire scl_hi    = scl_s[1] & scl_s[2];
    wire start_det = scl_hi & sda_s[2] & ~sda_s[1];
    wire stop_det  = scl_hi & ~sda_s[2] & sda_s[1];

    // ---------------------------------------------------------------
    // Control state
    // ---------------------------------------------------------------
    tew_dstate_t               state_r;
    logic [3:0]                bit_r;
    logic [7:0]                sh_r;
    logic [7:0]                tx_r;
    logic [7:0]                hi_r;
    logic                      page_r;
    logic                      mack_r;
    logic                      have_r;
    logic                      oe_r;
    logic [`TEW_ADDR_W-1:0]    addr_r;
    logic [19:0]               timer_r;

    wire dev_match = (sh_r[7:4] == `TEW_DEV_CODE)
                   & (sh_r[3] == csh_s[1])
                   & (sh_r[2] == csl_s[1]);
    wire rx_state  = (state_r == d_addr) | (state_r == d_whi)
                   | (state_r == d_wlo) | (state_r == d_wdat);
    wire byte_done = rx_state & scl_fall & (bit_r == 4'h7);
    wire ack_ok    = (state_r != d_addr) | dev_match;
    wire [7:0] rd_byte = mem[addr_r];
    wire prog_end  = (timer_r == 20'(PROG_CYCLES - 1));
    wire commit    = (state_r == d_busy) & (timer_r < 20'h00100);
    wire [7:0] cidx = timer_r[7:0];
    wire [7:0] lo_inc = addr_r[7:0] + 8'h01;

    tew_dstate_t rx_nxt;
    always_comb begin
        unique case (state_r)
            d_addr:  rx_nxt = !dev_match ? d_idle :
                              sh_r[0] ? d_rdat : d_whi;
            d_whi:   rx_nxt = d_wlo;
            d_wlo:   rx_nxt = d_wdat;
            d_wdat:  rx_nxt = d_wdat;
            default: rx_nxt = state_r;
        endcase
    end

    // ---------------------------------------------------------------
    // Protocol state machine
    // ---------------------------------------------------------------
    // A busy device ignores starts too, so polls go unanswered until
    // programming is over.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= d_idle;
            bit_r   <= 4'h0;
            oe_r    <= 1'b0;
            mack_r  <= 1'b0;
            timer_r <= 20'h00000;
        end else if (state_r == d_busy) begin
            timer_r <= timer_r + 20'h00001;
            if (prog_end) begin
                state_r <= d_idle;
            end
        end else if (start_det) begin
            state_r <= d_addr;
            bit_r   <= `TEW_BITS_PER_WORD;
            oe_r    <= 1'b0;
        end else if (stop_det) begin
            state_r <= (state_r == d_wdat && have_r) ? d_busy : d_idle;
            timer_r <= 20'h00000;
            oe_r    <= 1'b0;
        end else if (byte_done) begin
            state_r <= rx_nxt;
            bit_r   <= `TEW_BITS_PER_WORD;
            oe_r    <= ack_ok;
            mack_r  <= 1'b1;
        end else if (rx_state && scl_fall) begin
            bit_r   <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
            oe_r    <= 1'b0;
        end else if (state_r == d_rdat) begin
            if (scl_rise && bit_r == 4'h8) begin
                mack_r <= ~sda_s[1];
            end
            if (scl_fall) begin
                if (bit_r == 4'h8) begin
                    bit_r   <= 4'h0;
                    oe_r    <= mack_r & ~rd_byte[7];
                    state_r <= mack_r ? d_rdat : d_idle;
                end else if (bit_r == 4'h7) begin
                    bit_r <= 4'h8;
                    oe_r  <= 1'b0;
                end else begin
                    bit_r <= bit_r + 4'h1;
                    oe_r  <= ~tx_r[7];
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Address counter and data path
    // ---------------------------------------------------------------
    // The counter keeps its value across commands and carries no reset
    // beyond power-up.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sh_r    <= 8'h00;
            tx_r    <= 8'h00;
            hi_r    <= 8'h00;
            page_r  <= 1'b0;
            have_r  <= 1'b0;
            addr_r  <= '0;
            dirty_r <= '0;
        end else if (state_r == d_busy) begin
            if (commit) begin
                dirty_r[cidx] <= 1'b0;
            end
        end else if (start_det) begin
            have_r  <= 1'b0;
            dirty_r <= '0;
        end else begin
            if (rx_state && scl_rise) begin
                sh_r <= {sh_r[6:0], sda_s[1]};
            end
            if (byte_done) begin
                unique case (state_r)
                    d_addr: begin
                        page_r <= sh_r[1];
                        if (sh_r[0] && dev_match) begin
                            addr_r[16] <= sh_r[1];
                        end
                    end
                    d_whi:  hi_r <= sh_r;
                    d_wlo:  addr_r <= {page_r, hi_r, sh_r};
                    d_wdat: begin
                        addr_r[7:0] <= lo_inc;
                        if (!wp_s[1]) begin
                            dirty_r[addr_r[7:0]] <= 1'b1;
                            have_r <= 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
            if (state_r == d_rdat && scl_fall) begin
                if (bit_r == 4'h8 && mack_r) begin
                    tx_r   <= {rd_byte[6:0], 1'b0};
                    addr_r <= addr_r + 17'h00001;
                end else if (bit_r < 4'h7) begin
                    tx_r <= {tx_r[6:0], 1'b0};
                end
            end
        end
    end

    // Page buffer and array; the array is written only from the buffer
    // during programming, so a transfer cut off by a start is dropped.
    always_ff @(posedge clock) begin
        if (byte_done && state_r == d_wdat && !wp_s[1]) begin
            pbuf[addr_r[7:0]] <= sh_r;
        end
        if (commit && dirty_r[cidx]) begin
            mem[{addr_r[16:8], cidx}] <= pbuf[cidx];
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_r == d_busy);
        end
    end

    assign bus.d_sda_oe = oe_r;
    assign bus.d_sda_o  = 1'b0;
endmodule : tew_eeprom_dev

// *** rtl/tew_host.sv ***
// Two-wire bus controller that issues EEPROM commands.
`timescale 1ns/1ps
`include "tew_consts.svh"
module tew_host
    import tew_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset_n,
    tew_bus_if.host          bus,
    input  wire logic        req,
    input  tew_op_t          op,
    input  wire logic [1:0]  cs,
    input  wire logic [16:0] addr,
    input  wire logic [7:0]  len,
    input  wire logic [7:0]  wdata,
    output logic             ready,
    output logic             done,
    output logic             nack,
    output logic [7:0]       rdata,
    output logic             rdata_valid,
    output logic             wdata_take
);
    // ---------------------------------------------------------------
    // Quarter-bit divider and input synchroniser
    // ---------------------------------------------------------------
    localparam logic [5:0] QTR = 6'(`TEW_SCL_QTR_CYC);
    logic [5:0]  qcnt_r;
    logic [1:0]  sda_s;
    wire         tick = (qcnt_r == QTR - 6'h01);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            qcnt_r <= 6'h00;
            sda_s  <= 2'h3;
        end else begin
            qcnt_r <= tick ? 6'h00 : qcnt_r + 6'h01;
            sda_s  <= {sda_s[0], bus.sda};
        end
    end

    // ---------------------------------------------------------------
    // Command sequencer
    // ---------------------------------------------------------------
    tew_hstate_t  st_r;
    tew_op_t      op_r;
    logic [1:0]   cs_r;
    logic [16:0]  addr_r;
    logic [7:0]   len_r;
    logic [7:0]   cnt_r;
    logic [7:0]   rx_r;
    logic [1:0]   ph_r;
    logic [3:0]   bit_r;
    logic         ack_r;
    logic         rs_r;
    logic         scl_oe_r;
    logic         sda_oe_r;

    wire last    = (cnt_r == len_r);
    wire is_rd   = (st_r == h_rdat);
    wire [7:0] tx_byte =
        (st_r == h_dev)  ? {`TEW_DEV_CODE, cs_r, addr_r[16],
                            op_r == op_cur} :
        (st_r == h_devr) ? {`TEW_DEV_CODE, cs_r, addr_r[16], 1'b1} :
        (st_r == h_ahi)  ? addr_r[15:8] :
        (st_r == h_alo)  ? addr_r[7:0] : wdata;
    wire sda_rel = (st_r == h_recov) ? 1'b1 :
                   is_rd ? (bit_r[3] ? last : 1'b1) :
                   (bit_r[3] ? 1'b1 : tx_byte[~bit_r[2:0]]);
    wire bit_end = tick & (ph_r == 2'h3);
    wire tx_st   = (st_r == h_dev) | (st_r == h_devr) | (st_r == h_ahi)
                 | (st_r == h_alo) | (st_r == h_wdat);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= h_idle;
            op_r <= op_write;
            cs_r <= 2'h0;
            addr_r <= 17'h00000;
            len_r <= 8'h00;
            cnt_r <= 8'h00;
            rx_r <= 8'h00;
            ph_r <= 2'h0;
            bit_r <= 4'h0;
            ack_r <= 1'b0;
            rs_r <= 1'b0;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
            nack <= 1'b0;
            done <= 1'b0;
            rdata <= 8'h00;
            rdata_valid <= 1'b0;
            wdata_take <= 1'b0;
        end else begin
            done <= 1'b0;
            rdata_valid <= 1'b0;
            wdata_take <= 1'b0;
            if (st_r == h_idle) begin
                if (req) begin
                    op_r <= op;
                    cs_r <= cs;
                    addr_r <= addr;
                    len_r <= len;
                    cnt_r <= 8'h00;
                    rs_r <= 1'b0;
                    nack <= 1'b0;
                    ph_r <= 2'h0;
                    bit_r <= 4'h0;
                    st_r <= (op == op_recover) ? h_recov : h_start;
                end
            end else if (tick) begin
                ph_r <= ph_r + 2'h1;
                unique case (ph_r)
                    2'h0: sda_oe_r <= (st_r == h_start) ? 1'b0 :
                                      (st_r == h_stop) ? 1'b1 : ~sda_rel;
                    2'h1: scl_oe_r <= 1'b0;
                    2'h2: begin
                        if (st_r == h_start) begin
                            sda_oe_r <= 1'b1;
                        end else if (st_r == h_stop) begin
                            sda_oe_r <= 1'b0;
                        end else begin
                            rx_r  <= {rx_r[6:0], sda_s[1]};
                            ack_r <= ~sda_s[1];
                        end
                    end
                    2'h3: scl_oe_r <= (st_r != h_stop);
                endcase
            end
            if (bit_end && st_r != h_idle) begin
                bit_r <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
                if (is_rd && bit_r == 4'h7) begin
                    rdata <= rx_r;
                    rdata_valid <= 1'b1;
                end
                if (st_r == h_start) begin
                    bit_r <= 4'h0;
                    st_r  <= (op_r == op_recover) ? h_stop :
                             rs_r ? h_devr : h_dev;
                end else if (st_r == h_stop) begin
                    st_r <= h_idle;
                    done <= 1'b1;
                end else if (bit_r == 4'h8) begin
                    if (tx_st && !ack_r) begin
                        nack <= 1'b1;
                        st_r <= h_stop;
                    end else begin
                        unique case (st_r)
                            h_recov: st_r <= h_start;
                            h_dev:   st_r <= (op_r == op_cur) ? h_rdat
                                                              : h_ahi;
                            h_ahi:   st_r <= h_alo;
                            h_alo: begin
                                rs_r <= 1'b1;
                                st_r <= (op_r == op_write) ? h_wdat
                                                           : h_start;
                            end
                            h_devr:  st_r <= h_rdat;
                            default: begin
                                wdata_take <= (st_r == h_wdat);
                                cnt_r <= cnt_r + 8'h01;
                                st_r  <= last ? h_stop : st_r;
                            end
                        endcase
                    end
                end
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ready <= 1'b0;
        end else begin
            ready <= (st_r == h_idle) & ~req;
        end
    end

    assign bus.scl_o    = 1'b0;
    assign bus.scl_oe   = scl_oe_r;
    assign bus.h_sda_o  = 1'b0;
    assign bus.h_sda_oe = sda_oe_r;
endmodule : tew_host

// *** rtl/tew_pkg.sv ***
// Types shared by both ends of the two-wire EEPROM link.
package tew_pkg;
    typedef enum logic [1:0] {
        op_write,
        op_read,
        op_cur,
        op_recover
    } tew_op_t;

    typedef enum {
        d_idle, d_addr, d_whi, d_wlo, d_wdat, d_rdat, d_busy
    } tew_dstate_t;

    typedef enum {
        h_idle, h_recov, h_start, h_dev, h_ahi, h_alo, h_wdat,
        h_devr, h_rdat, h_stop
    } tew_hstate_t;
endpackage : tew_pkg

// *** sim/test_two_wire_serial_eeprom_target.sv ***
// Self-checking bench joining the controller and the EEPROM target.
`timescale 1ns/1ps
module test_two_wire_serial_eeprom_target;
    import tew_pkg::*;
    localparam int PC = 300;
    logic        clock, reset_n, req, wp, busy, ready, done, nack, rv, wt;
    logic        sp, lp;
    logic [1:0]  cs, pins;
    logic [16:0] addr;
    logic [7:0]  len, wdata, rdata, sh;
    tew_op_t     op;
    int          num_errors, checked, bn, bc, cnt;
    int unsigned rs;
    logic [7:0]  mem [int];
    logic [7:0]  wq [$];
    logic [7:0]  rq [$];
    tew_bus_if bus ();
    tew_eeprom_dev #(.PROG_CYCLES(PC)) u_tew_eeprom_dev (
        .clock(clock), .reset_n(reset_n), .bus(bus),
        .chip_select_hi_pin(pins[1]), .chip_select_lo_pin(pins[0]),
        .write_protect(wp), .busy(busy));
    tew_host u_tew_host (
        .clock(clock), .reset_n(reset_n), .bus(bus), .req(req), .op(op),
        .cs(cs), .addr(addr), .len(len), .wdata(wdata), .ready(ready),
        .done(done), .nack(nack), .rdata(rdata), .rdata_valid(rv),
        .wdata_take(wt));
    tew_link_chk u_tew_link_chk (
        .clock(clock), .reset_n(reset_n), .scl_o(bus.scl_o),
        .scl_oe(bus.scl_oe), .h_sda_o(bus.h_sda_o), .h_sda_oe(bus.h_sda_oe),
        .d_sda_o(bus.d_sda_o), .d_sda_oe(bus.d_sda_oe), .scl(bus.scl),
        .sda(bus.sda));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    function automatic logic [7:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs[7:0];
    endfunction : rnd

    task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop

    // Wire watch: first byte after each start, and busy period length.
    always @(posedge clock) begin
        if (bus.scl && sp && !bus.sda) bn <= 0;
        else if (bus.scl && !lp && bn < 8) begin
            sh <= {sh[6:0], bus.sda};
            bn <= bn + 1;
        end
        sp <= bus.sda;
        lp <= bus.scl;
        if (busy === 1'b1) bc <= bc + 1;
        else if (bc != 0) begin
            cmp(17'(bc), 17'(PC));
            bc <= 0;
        end
    end

    // One command through the controller, then the reference model.
    task automatic run(input tew_op_t o, input logic [16:0] a, input int l,
                       input logic [1:0] c, input logic xn);
        int k;
        logic [7:0] d [$];
        d = wq;
        @(posedge clock);
        op <= o;
        addr <= a;
        len <= 8'(l);
        cs <= c;
        wdata <= (d.size() > 0) ? d[0] : 8'h00;
        req <= 1'b1;
        @(posedge clock);
        req <= 1'b0;
        cmp(17'(ready), 17'h00001);
        rq = {};
        k = 0;
        while (done !== 1'b1 && k < 20000) begin
            if (rv === 1'b1) rq.push_back(rdata);
            if (wt === 1'b1) begin
                void'(wq.pop_front());
                wdata <= (wq.size() > 0) ? wq[0] : 8'h00;
            end
            @(posedge clock);
            k++;
        end
        if (k == 20000) begin
            num_errors++;
            report_and_stop();
        end
        cmp(17'(ready), 17'h00000);
        cmp(17'(nack), 17'(xn));
        $display("command %0d finished", o);
        wq = {};
        if (xn) return;
        if (o == op_write && !wp)
            foreach (d[i]) mem[{a[16:8], a[7:0] + 8'(i)}] = d[i];
        if (o == op_read) cnt = a;
        if (o == op_read || o == op_cur) begin
            cmp(17'(rq.size()), 17'(l + 1));
            foreach (rq[i]) begin
                cmp(17'(rq[i]), 17'(mem[cnt]));
                cnt = (cnt + 1) % 131072;
            end
        end
    endtask : run

    initial begin
        reset_n = 1'b0;
        req = 1'b0;
        wp = 1'b0;
        pins = 2'b10;
        cs = 2'b10;
        addr = 17'h0;
        len = 8'h0;
        wdata = 8'h0;
        op = op_write;
        sp = 1'b1;
        lp = 1'b1;
        rs = 2;
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        run(op_recover, 17'h0, 0, 2'b10, 1'b0);
        wq = {rnd(), rnd()};
        run(op_write, 17'h0, 1, 2'b10, 1'b0);
        cmp(17'(sh), 17'h000a8);
        run(op_cur, 17'h0, 0, 2'b10, 1'b1);
        repeat (4) wq.push_back(rnd());
        run(op_write, 17'h1fffe, 3, 2'b10, 1'b0);
        run(op_read, 17'h1fffe, 2, 2'b10, 1'b1);
        run(op_read, 17'h1fffe, 2, 2'b10, 1'b0);
        for (int c = 0; c < 4; c++)
            run(op_cur, 17'h0, 0, 2'(c), c != 2);
        run(op_read, 17'h1ff00, 1, 2'b10, 1'b0);
        wp <= 1'b1;
        wq = {~mem[0]};
        run(op_write, 17'h0, 0, 2'b10, 1'b0);
        wp <= 1'b0;
        run(op_read, 17'h0, 0, 2'b10, 1'b0);
        report_and_stop();
    end
endmodule : test_two_wire_serial_eeprom_target

// *** sim/tew_link_chk.sv ***
// Concurrent checks on the open-drain link between controller and EEPROM.
`timescale 1ns/1ps
module tew_link_chk (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic h_sda_o,
    input wire logic h_sda_oe,
    input wire logic d_sda_o,
    input wire logic d_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    logic       scl_p_r, sda_p_r, frm_r, dat_r, rw_r;
    logic [3:0] bit_r;
    wire logic  rise = scl & ~scl_p_r;
    wire logic  strt = scl & sda_p_r & ~sda;
    wire logic  stp  = scl & ~sda_p_r & sda;
    wire logic  last = (bit_r == 4'h8);

    // Bit index counts SCL rises inside a frame; any start restarts it.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            {scl_p_r, sda_p_r, frm_r, dat_r, rw_r, bit_r} <= 9'h180;
        end else begin
            scl_p_r <= scl;
            sda_p_r <= sda;
            if (strt | stp) begin
                frm_r <= strt;
                dat_r <= 1'b0;
                bit_r <= 4'h0;
            end else if (rise) begin
                bit_r <= last ? 4'h0 : bit_r + 4'h1;
                dat_r <= dat_r | last;
                if (bit_r == 4'h7 && !dat_r) rw_r <= sda;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    chk_start_hold: assert property (
        strt |-> scl [*8])
        else $error("start not held with clock high");
    chk_stop_idle: assert property (
        stp |-> sda [*8])
        else $error("data line fell right after stop");
    chk_data_stable: assert property (
        rise && frm_r |=> $stable(sda) [*8])
        else $error("data moved while clock high");
    chk_dev_edge: assert property (
        $changed(d_sda_oe) |-> !scl)
        else $error("target moved data while clock high");
    chk_addr_quiet: assert property (
        rise && frm_r && !dat_r && !last |-> !d_sda_oe)
        else $error("target drove during address bits");
    chk_ack_slot: assert property (
        rise && frm_r && !dat_r && last |-> !h_sda_oe)
        else $error("controller held data in address ack slot");
    chk_write_ack: assert property (
        rise && frm_r && dat_r && !rw_r && last |-> d_sda_oe && !sda)
        else $error("write byte not acknowledged");
    chk_read_free: assert property (
        rise && frm_r && dat_r && rw_r && last |-> !d_sda_oe)
        else $error("target held data in read ack slot");
    chk_recov_free: assert property (
        rise && !frm_r |-> !h_sda_oe)
        else $error("controller drove data outside a frame");
    chk_dev_od: assert property (
        d_sda_oe |-> !d_sda_o && !sda)
        else $error("target drive is not a low level");
    chk_host_od: assert property (
        (scl_oe |-> !scl_o && !scl) and (h_sda_oe |-> !h_sda_o && !sda))
        else $error("controller drive is not a low level");
endmodule : tew_link_chk
